// *** rtl/emx_pkg.sv ***
`default_nettype none
package emx_pkg;

	// Channel field and address widths
	localparam int CHAN_W = 6;
	localparam int ADDR_W = 3;
	localparam int MUX_INPUTS = 4;
	localparam int SEL_W = 2;
	// Externally multiplexed channel range
	localparam logic [5:0] EXT_CHAN_FIRST = 6'h00;
	localparam logic [5:0] EXT_CHAN_LAST = 6'h1f;
	// Internal channel limit without external muxing
	localparam int INT_CHAN_MAX = 16;
	// Pins, direct channels and totals
	localparam int CONV_PINS = 21;
	localparam int TOTAL_CHAN_MAX = 41;
	localparam int TRIG_SHARED = 2;
	// Port A width and address bit positions
	localparam int PORT_W = 8;
	localparam logic [7:0] ADDR_PIN_MASK = 8'h07;
	// Reset values
	localparam logic [2:0] ADDR_RST = 3'h0;
	localparam logic [3:0] CHIPS_RST = 4'h0;

	// Command presented for one conversion
	typedef struct packed {
		logic valid;
		logic [5:0] chan;
	} emx_cmd_type;

	// Analog routing decision for one conversion
	typedef struct packed {
		logic valid;
		logic external;
		logic [1:0] mux_sel;
		logic [5:0] chan;
	} emx_route_type;

endpackage : emx_pkg
`default_nettype wire

// *** rtl/emx_chan_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
module emx_chan_decode (
	// Channel in
	input wire logic [5:0] chan,
	input wire logic mux_en,
	// Decoded outputs
	output logic is_ext,
	output logic [2:0] addr,
	output logic [1:0] sel
);
	import emx_pkg::*;

	// Split channel into mux address and mux input select
	always_comb begin
		is_ext = mux_en && (chan <= EXT_CHAN_LAST);
		addr = chan[2:0];
		sel = chan[4:3];
	end
endmodule : emx_chan_decode
`default_nettype wire

// *** rtl/emx_pin_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none
module emx_pin_ctrl #(
	parameter int W = 8
) (
	// Port state
	input wire logic [W-1:0] port_dir,
	input wire logic [W-1:0] port_latch,
	input wire logic [W-1:0] pin_in,
	input wire logic mux_en,
	input wire logic [2:0] addr_latch,
	// Pin drive and readback
	output logic [W-1:0] pin_oe,
	output logic [W-1:0] port_rd
);
	import emx_pkg::*;

	// Per pin: open drain pull down, forced for address bits in mux mode
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_pin
			if (g < ADDR_W) begin : g_addr
				// Mux mode overrides direction and reads the latch
				assign pin_oe[g] = mux_en ? ~addr_latch[g]
					: port_dir[g] & ~port_latch[g];
				assign port_rd[g] = mux_en ? addr_latch[g]
					: (port_dir[g] ? port_latch[g] : pin_in[g]);
			end else begin : g_gp
				// Plain port bit, never touched by mux mode
				assign pin_oe[g] = port_dir[g] & ~port_latch[g];
				assign port_rd[g] = port_dir[g] ? port_latch[g] : pin_in[g];
			end
		end
	endgenerate
endmodule : emx_pin_ctrl
`default_nettype wire

// *** rtl/emx_mux_ctrl.sv ***
// Operation
// - Supports one to four external mux chips
// - Up to 32 external channels converted
// - Channel taken from each command word
// - Three address outputs select one of eight
// - Open drain address from command channel
// - Channel picks one of four mux inputs
// - External channels are numbers 0 to 31
// - Address pins are forced outputs only in mux mode
// - Queue features same for both channel kinds
// - Internal muxing serves at most 16 channels
// - Three inputs become address, one per chip
// - 21 pins give at most 41 channels
// - Counts assume triggers share two analog pins
// - Direction ignored, address pins forced driven; each is pulled low only where its address latch bit is zero
// - Port read returns address latch bits
`timescale 1ns/100ps
`default_nettype none
module emx_mux_ctrl #(
	parameter int NUM_CHIPS = 4,
	parameter int PORT_W = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Mode bit from converter_control_reg_zero
	input wire logic mux_en,
	// Command from the queue engine
	input wire emx_pkg::emx_cmd_type cmd,
	// Routing toward the sample stage
	output emx_pkg::emx_route_type route,
	// Port A pin interface
	input wire logic [PORT_W-1:0] port_dir,
	input wire logic [PORT_W-1:0] port_latch,
	input wire logic [PORT_W-1:0] pin_in,
	output logic [PORT_W-1:0] pin_out,
	output logic [PORT_W-1:0] pin_oe,
	output logic [PORT_W-1:0] port_rd,
	// Channel availability
	output logic [5:0] total_chan
);
	import emx_pkg::*;

	logic dec_ext; // Command channel is external
	logic [2:0] dec_addr; // Decoded address
	logic [1:0] dec_sel; // Decoded mux input select
	logic [2:0] mux_address_out_r; // Address latch
	emx_route_type route_r; // Registered routing
	logic [5:0] total_nxt; // Channel count

	// Channel decode
	emx_chan_decode u_dec (
		.chan(cmd.chan),
		.mux_en(mux_en),
		.is_ext(dec_ext),
		.addr(dec_addr),
		.sel(dec_sel)
	);

	// Address latch loads from each external command
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mux_address_out_r <= ADDR_RST;
		end else if (cmd.valid && dec_ext) begin
			mux_address_out_r <= dec_addr;
		end
	end

	// Route each command to a mux input or direct channel
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			route_r <= '0;
		end else begin
			route_r.valid <= cmd.valid;
			route_r.external <= dec_ext;
			route_r.mux_sel <= dec_ext ? dec_sel : 2'h0;
			route_r.chan <= cmd.chan;
		end
	end
	assign route = route_r;

	// Pin drive and readback, open drain so data pins stay low
	emx_pin_ctrl #(.W(PORT_W)) u_pins (
		.port_dir(port_dir),
		.port_latch(port_latch),
		.pin_in(pin_in),
		.mux_en(mux_en),
		.addr_latch(mux_address_out_r),
		.pin_oe(pin_oe),
		.port_rd(port_rd)
	);
	assign pin_out = '0;

	// Available channels: 16 direct, or 13-n direct plus eight per chip
	always_comb begin
		if (mux_en && NUM_CHIPS > 0) begin
			total_nxt = 6'(INT_CHAN_MAX - ADDR_W - NUM_CHIPS
				+ (NUM_CHIPS << ADDR_W));
		end else begin
			total_nxt = 6'(INT_CHAN_MAX);
		end
	end
	assign total_chan = total_nxt;

	// Address latch follows external commands
	property p_addr_load;
		@(posedge sys_clk) disable iff (!arst_n)
		(cmd.valid && mux_en && cmd.chan <= EXT_CHAN_LAST)
			|=> mux_address_out_r == $past(cmd.chan[2:0]);
	endproperty
	a_addr_load: assert property (p_addr_load)
		else $error("address latch did not load");

	// Mux input select from upper channel bits
	property p_sel;
		@(posedge sys_clk) disable iff (!arst_n)
		(cmd.valid && mux_en && cmd.chan <= EXT_CHAN_LAST)
			|=> route.external && route.mux_sel == $past(cmd.chan[4:3]);
	endproperty
	a_sel: assert property (p_sel)
		else $error("mux input select wrong");

	// Address pins readback equals latch in mux mode
	property p_read;
		@(posedge sys_clk) disable iff (!arst_n)
		mux_en |-> port_rd[2:0] == mux_address_out_r;
	endproperty
	a_read: assert property (p_read)
		else $error("port readback not latch");

	// Address pins pulled low exactly where latch bit is zero
	property p_drive;
		@(posedge sys_clk) disable iff (!arst_n)
		mux_en |-> pin_oe[2:0] == ~mux_address_out_r;
	endproperty
	a_drive: assert property (p_drive)
		else $error("address pins not forced");

	// Channels above 31 never external
	property p_range;
		@(posedge sys_clk) disable iff (!arst_n)
		(cmd.valid && cmd.chan > EXT_CHAN_LAST) |=> !route.external;
	endproperty
	a_range: assert property (p_range)
		else $error("channel above 31 routed external");

	// Latch holds when no external command arrives
	property p_hold;
		@(posedge sys_clk) disable iff (!arst_n)
		!(cmd.valid && dec_ext) |=> $stable(mux_address_out_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("address latch changed spuriously");

	// Without mux mode, routing is never external
	property p_nomux;
		@(posedge sys_clk) disable iff (!arst_n)
		!mux_en |=> !route.external;
	endproperty
	a_nomux: assert property (p_nomux)
		else $error("external route without mux mode");

	// Valid passes straight through one cycle later
	property p_valid;
		@(posedge sys_clk) disable iff (!arst_n)
		cmd.valid |=> route.valid;
	endproperty
	a_valid: assert property (p_valid)
		else $error("command lost");

	// Steps of a conversion, shared by the checks below
	// One command that the decoder calls external
	sequence s_ext_cmd;
		cmd.valid && mux_en && (cmd.chan <= EXT_CHAN_LAST);
	endsequence

	// One command that stays on a direct channel
	sequence s_direct_cmd;
		cmd.valid && !(mux_en && (cmd.chan <= EXT_CHAN_LAST));
	endsequence

	// Route shows an external conversion
	sequence s_ext_route;
		route.valid && route.external;
	endsequence

	// External command becomes an external conversion
	property p_ext_route;
		@(posedge sys_clk) disable iff (!arst_n)
		s_ext_cmd |=> s_ext_route;
	endproperty
	a_ext_route: assert property (p_ext_route)
		else $error("external command not routed external");

	// Direct commands keep mux select at zero
	property p_direct_sel;
		@(posedge sys_clk) disable iff (!arst_n)
		s_direct_cmd |=> !route.external && route.mux_sel == 2'h0;
	endproperty
	a_direct_sel: assert property (p_direct_sel)
		else $error("direct command got a mux select");

	// Direct commands leave the address latch alone
	property p_direct_hold;
		@(posedge sys_clk) disable iff (!arst_n)
		s_direct_cmd |=> $stable(mux_address_out_r);
	endproperty
	a_direct_hold: assert property (p_direct_hold)
		else $error("direct command moved address latch");

	// Channel number passes through with the command
	property p_chan_pass;
		@(posedge sys_clk) disable iff (!arst_n)
		cmd.valid |=> route.chan == $past(cmd.chan);
	endproperty
	a_chan_pass: assert property (p_chan_pass)
		else $error("routed channel differs from command");

	// No command, no conversion
	property p_idle;
		@(posedge sys_clk) disable iff (!arst_n)
		!cmd.valid |=> !route.valid;
	endproperty
	a_idle: assert property (p_idle)
		else $error("conversion without command");

	// Address pins follow the loaded channel while mode stays on
	property p_pins_follow;
		@(posedge sys_clk) disable iff (!arst_n)
		s_ext_cmd ##1 mux_en |-> pin_oe[2:0] == ~$past(cmd.chan[2:0]);
	endproperty
	a_pins_follow: assert property (p_pins_follow)
		else $error("address pins do not show channel");

	// Mux mode adds channels but never beyond the total limit
	property p_tot_mux;
		@(posedge sys_clk) disable iff (!arst_n)
		mux_en |-> total_chan > 6'(INT_CHAN_MAX)
			&& total_chan <= 6'(TOTAL_CHAN_MAX);
	endproperty
	a_tot_mux: assert property (p_tot_mux)
		else $error("channel total out of range");

	// Without mux mode only internal channels exist
	property p_tot_direct;
		@(posedge sys_clk) disable iff (!arst_n)
		!mux_en |-> total_chan == 6'(INT_CHAN_MAX);
	endproperty
	a_tot_direct: assert property (p_tot_direct)
		else $error("direct channel total wrong");

	// Address pins and chip inputs come out of the direct set
	property p_pin_trade;
		@(posedge sys_clk) disable iff (!arst_n)
		mux_en |-> int'(total_chan) + ADDR_W + NUM_CHIPS
			== INT_CHAN_MAX + (NUM_CHIPS << ADDR_W);
	endproperty
	a_pin_trade: assert property (p_pin_trade)
		else $error("pin trade in channel total wrong");

	// Total depends on the mode alone
	property p_tot_stable;
		@(posedge sys_clk) disable iff (!arst_n)
		$stable(mux_en) |-> $stable(total_chan);
	endproperty
	a_tot_stable: assert property (p_tot_stable)
		else $error("channel total moved without mode change");

	// External conversions only carry channels 0 to 31
	property p_ext_range;
		@(posedge sys_clk) disable iff (!arst_n)
		s_ext_route |-> route.chan <= EXT_CHAN_LAST;
	endproperty
	a_ext_range: assert property (p_ext_range)
		else $error("external route with high channel");

	// Mux select is the upper pair of channel bits
	property p_sel_bits;
		@(posedge sys_clk) disable iff (!arst_n)
		s_ext_route |-> route.mux_sel == route.chan[4:3];
	endproperty
	a_sel_bits: assert property (p_sel_bits)
		else $error("mux select not upper channel bits");

	// Latch matches the low channel bits of the conversion
	property p_addr_match;
		@(posedge sys_clk) disable iff (!arst_n)
		s_ext_route |-> mux_address_out_r == route.chan[2:0];
	endproperty
	a_addr_match: assert property (p_addr_match)
		else $error("address latch not low channel bits");

	// Outside mux mode the low pins read as a plain port
	property p_gp_read;
		@(posedge sys_clk) disable iff (!arst_n)
		!mux_en |-> port_rd[2:0] == ((port_dir[2:0] & port_latch[2:0])
			| (~port_dir[2:0] & pin_in[2:0]));
	endproperty
	a_gp_read: assert property (p_gp_read)
		else $error("low port bits read wrong");

	// Outside mux mode the low pins drive as a plain port
	property p_gp_drive;
		@(posedge sys_clk) disable iff (!arst_n)
		!mux_en |-> pin_oe[2:0] == (port_dir[2:0] & ~port_latch[2:0]);
	endproperty
	a_gp_drive: assert property (p_gp_drive)
		else $error("low port bits driven wrong");

	// Upper pins are never forced by the mode
	property p_hi_drive;
		@(posedge sys_clk) disable iff (!arst_n)
		pin_oe[7:3] == (port_dir[7:3] & ~port_latch[7:3]);
	endproperty
	a_hi_drive: assert property (p_hi_drive)
		else $error("upper port bits driven wrong");

	// Upper pins read as a plain port in either mode
	property p_hi_read;
		@(posedge sys_clk) disable iff (!arst_n)
		port_rd[7:3] == ((port_dir[7:3] & port_latch[7:3])
			| (~port_dir[7:3] & pin_in[7:3]));
	endproperty
	a_hi_read: assert property (p_hi_read)
		else $error("upper port bits read wrong");

endmodule : emx_mux_ctrl
`default_nettype wire

// *** sim/emx_ext_mux_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Eight-input analog switch chips on one shared address bus
module emx_ext_mux_model (
	// Address line levels
	input wire logic [2:0] addr_lvl,
	// Input picked on every chip
	output logic [2:0] pick
);
	// All chips decode the same three lines
	// Each chip feeds its own analog input, so one pick serves all
	assign pick = addr_lvl;
endmodule : emx_ext_mux_model
`default_nettype wire

// *** sim/emx_mux_ctrl_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module emx_mux_ctrl_tb_top;
	import emx_pkg::*;
	// Design stimulus and outputs
	logic sys_clk, arst_n, mux_en;
	emx_cmd_type cmd;
	emx_route_type route;
	logic [7:0] dir, lat, ext_lvl, pin_in, pin_out, pin_oe, port_rd;
	logic [5:0] total_chan;
	logic [2:0] pick, exp_l;
	int fail_count, check_count;
	// Notes: route then latch
	logic [12:0] q[$];
	logic [12:0] n;
	// Pulled-up lines, low while a driver pulls
	// Address lines have only the pull-up once the mode drives them
	assign pin_in = ~pin_oe & {ext_lvl[7:3], mux_en ? 3'h7 : ext_lvl[2:0]};
	emx_mux_ctrl u_emx_mux_ctrl (.sys_clk(sys_clk), .arst_n(arst_n),
		.mux_en(mux_en), .cmd(cmd), .route(route), .port_dir(dir),
		.port_latch(lat), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .port_rd(port_rd), .total_chan(total_chan));
	emx_ext_mux_model u_emx_ext_mux_model (.addr_lvl(pin_in[2:0]),
		.pick(pick));
	// Compare and count
	task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	// Verdict and end of run
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done
	// Issue one command and note the expected answer
	task automatic send(logic en, logic [5:0] c);
		logic ext;
		ext = en && c <= EXT_CHAN_LAST;
		if (ext)
			exp_l = c[2:0];
		q.push_back({1'b1, ext, ext ? c[4:3] : 2'h0, c, exp_l});
		mux_en <= en;
		cmd <= '{valid: 1'b1, chan: c};
		@(posedge sys_clk);
	endtask : send
	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// Output watcher, after each edge settles
	always @(posedge sys_clk) begin
		#1;
		if (arst_n) begin
			if (route.valid === 1'b1) begin
				n = q.size() ? q.pop_front() : 13'h0;
				chk("route", route, n[12:3]);
				if (mux_en) begin
					chk("addr_rd", port_rd[2:0], n[2:0]);
					chk("addr_oe", pin_oe[2:0], 3'(~n[2:0]));
					chk("pick", pick, n[2:0]);
				end
			end
			if (!mux_en) begin
				chk("oe_lo", pin_oe[2:0], dir[2:0] & ~lat[2:0]);
				chk("rd_lo", port_rd[2:0], dir[2:0] & lat[2:0]
					| ~dir[2:0] & pin_in[2:0]);
			end
			chk("oe_hi", pin_oe[7:3], dir[7:3] & ~lat[7:3]);
			chk("rd_hi", port_rd[7:3], dir[7:3] & lat[7:3]
				| ~dir[7:3] & pin_in[7:3]);
			chk("out", pin_out, 8'h00);
			chk("chans", total_chan, mux_en ? 6'h29 : 6'h10);
		end
	end
	// Hang guard
	initial begin
		#80000;
		fail_count++;
		test_done();
	end
	// Main sequence
	initial begin
		arst_n = 1'b0;
		mux_en = 1'b0;
		cmd = '0;
		dir = 8'h00;
		lat = 8'h00;
		ext_lvl = 8'hff;
		exp_l = 3'h0;
		fail_count = 0;
		check_count = 0;
		void'($urandom(32'hb96d));
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		// Every channel back to back, mode on then off
		for (int i = 0; i < 64; i++)
			send(1'b1, 6'(i));
		for (int i = 0; i < 64; i++)
			send(1'b0, 6'(i));
		// Random channels, modes and port settings
		repeat (300) begin
			dir <= 8'($urandom);
			lat <= 8'($urandom);
			ext_lvl <= 8'($urandom);
			send(1'($urandom), 6'($urandom));
		end
		// Reset in mid-run with the mode on
		cmd <= '0;
		mux_en <= 1'b1;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk("rst_route", route, 10'h000);
		chk("rst_oe", pin_oe[2:0], 3'h7);
		exp_l = 3'h0;
		@(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		send(1'b1, 6'h1f);
		send(1'b1, 6'h20);
		send(1'b1, 6'h00);
		cmd <= '0;
		repeat (3) @(posedge sys_clk);
		chk("left", 16'(q.size()), 16'h0000);
		test_done();
	end
endmodule : emx_mux_ctrl_tb_top
`default_nettype wire
